/* File: hdl/esx_pkg.sv */
package esx_pkg;

  // register map
  localparam logic [7:0] ESX_CTRL_OFS = 8'h00;
  localparam logic [7:0] ESX_SYND_OFS = 8'h04;
  localparam logic [7:0] ESX_STAT_OFS = 8'h08;

  // control register fields
  localparam int         ESX_CTRL_VEC_BIT     = 0;
  localparam int         ESX_CTRL_NARROW_BIT  = 1;
  localparam int         ESX_CTRL_PASSAL_BIT  = 2;
  localparam int         ESX_CTRL_NOFAIL_BIT  = 3;
  localparam int         ESX_CTRL_W           = 4;
  localparam logic [3:0] ESX_CTRL_RESET       = 4'h1;

  // exception classes
  localparam logic [5:0] ESX_EC_UNKNOWN = 6'h00;
  localparam logic [5:0] ESX_EC_FP      = 6'h07;
  localparam logic [5:0] ESX_EC_SYSREG  = 6'h18;
  localparam logic [5:0] ESX_EC_VEC     = 6'h19;

  // syndrome field positions
  localparam int         ESX_CV_BIT    = 24;
  localparam int         ESX_CONDITION_CODE_FIELD_LSB  = 20;
  localparam int         ESX_PASSU_BIT = 19;
  localparam int         ESX_OP0_LSB   = 20;
  localparam int         ESX_OP2_LSB   = 17;
  localparam int         ESX_OP1_LSB   = 14;
  localparam int         ESX_CRN_LSB   = 10;
  localparam int         ESX_RT_LSB    = 5;
  localparam int         ESX_CRM_LSB   = 1;
  localparam logic [3:0] ESX_CONDITION_CODE_FIELD_ALWAYS = 4'hE;

  typedef enum logic [2:0] {
    EK_FP, EK_VEC, EK_ILLEGAL, EK_ALIGN, EK_HVC, EK_SVC, EK_SMC, EK_SYSREG
  } esx_kind_type;

  typedef enum logic [1:0] {IS_64, IS_WIDE, IS_NARROW} esx_isa_type;

  typedef struct packed {
    esx_kind_type kind;
    esx_isa_type  isa;
    logic [1:0]   curLevel;
    logic [1:0]   trapTarget;
    logic [23:0]  callImmediate;
    logic [3:0]   condCode;
    logic         isCond;
    logic         passedCheck;
    logic [1:0]   sysopFirst;
    logic [2:0]   sysopSecond;
    logic [2:0]   sysopThird;
    logic [3:0]   sysPrimaryRegnum;
    logic [3:0]   sysSecondaryRegnum;
    logic [4:0]   transferRegnum;
    logic         isRead;
  } esx_exc_type;

  typedef struct packed {
    logic fpAccessEnableL1;
    logic fpAccessEnableL2;
    logic fpTrapBitL2;
    logic fpTrapBitL3;
    logic vectorAccessEnableL1;
    logic vectorAccessEnableL2;
    logic vectorTrapL2;
    logic vectorEnableL3;
    logic monitorCallTrap;
  } esx_trap_ctrl_type;

  typedef struct packed {
    logic [5:0]  exceptionClass;
    logic [24:0] syndromeDetail;
    logic [1:0]  targetLevel;
  } esx_report_type;

endpackage : esx_pkg

/* File: hdl/esx_syndrome_encoder.sv */
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module esx_syndrome_encoder #(
  parameter logic [5:0] ILLEGAL_EC = 6'h30,
  parameter logic [5:0] ALIGN_EC   = 6'h31,
  parameter logic [5:0] SVC32_EC   = 6'h32,
  parameter logic [5:0] SVC64_EC   = 6'h33,
  parameter logic [5:0] HVC_EC     = 6'h34,
  parameter logic [5:0] SMC32_EC   = 6'h35,
  parameter logic [5:0] SMC64_EC   = 6'h36
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // exception request from decode
  input  wire logic                       excTake,
  input  wire esx_pkg::esx_exc_type       excInfo,
  input  wire esx_pkg::esx_trap_ctrl_type trapCtrl,
  // syndrome report
  output logic                            reportValid,
  output esx_pkg::esx_report_type         report,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr
);
  import esx_pkg::*;

  logic [ESX_CTRL_W-1:0] ctrl_q;
  esx_report_type        report_q;
  esx_report_type        report_d;
  logic                  valid_q;
  logic                  raise_d;
  logic [15:0]           count_q;
  logic [15:0]           dropped_q;
  logic [31:0]           prdata_q;
  logic                  err_q;
  logic [1:0]            fpLevel;
  logic                  fpHit;
  logic [1:0]            vecLevel;
  logic                  vecHit;
  logic [4:0]            cvCond;
  logic                  passUncertain;
  logic                  smcTrapped;

  // lowest blocking level wins, as each level only sees traps from below
  always_comb begin
    fpHit   = 1'b1;
    fpLevel = 2'd1;
    if (excInfo.curLevel <= 2'd1 && !trapCtrl.fpAccessEnableL1) begin
      fpLevel = 2'd1;
    end else if (excInfo.curLevel <= 2'd2 &&
                 (!trapCtrl.fpAccessEnableL2 || trapCtrl.fpTrapBitL2)) begin
      fpLevel = 2'd2;
    end else if (trapCtrl.fpTrapBitL3) begin
      fpLevel = 2'd3;
    end else begin
      fpHit = 1'b0;
    end
  end

  always_comb begin
    vecHit   = 1'b1;
    vecLevel = 2'd1;
    if (excInfo.curLevel <= 2'd1 && !trapCtrl.vectorAccessEnableL1) begin
      vecLevel = 2'd1;
    end else if (excInfo.curLevel <= 2'd2 &&
                 (!trapCtrl.vectorAccessEnableL2 || trapCtrl.vectorTrapL2)) begin
      vecLevel = 2'd2;
    end else if (!trapCtrl.vectorEnableL3) begin
      vecLevel = 2'd3;
    end else begin
      vecHit = 1'b0;
    end
  end

  // condition-valid and condition code for trapped instructions
  always_comb begin
    cvCond = {1'b1, ESX_CONDITION_CODE_FIELD_ALWAYS};
    unique case (excInfo.isa)
      IS_64: cvCond = {1'b1, ESX_CONDITION_CODE_FIELD_ALWAYS};
      IS_WIDE: begin
        if (excInfo.isCond && !(excInfo.passedCheck && ctrl_q[ESX_CTRL_PASSAL_BIT])) begin
          cvCond = {1'b1, excInfo.condCode};
        end else begin
          cvCond = {1'b1, ESX_CONDITION_CODE_FIELD_ALWAYS};
        end
      end
      IS_NARROW: begin
        // unknown condition is reported as zero when condition-valid is clear
        if (ctrl_q[ESX_CTRL_NARROW_BIT]) begin
          cvCond = {1'b1, excInfo.isCond ? excInfo.condCode : ESX_CONDITION_CODE_FIELD_ALWAYS};
        end else begin
          cvCond = 5'h00;
        end
      end
      default: cvCond = {1'b1, ESX_CONDITION_CODE_FIELD_ALWAYS};
    endcase
  end

  // a fail that is never trapped lets the flag read zero throughout
  assign passUncertain = excInfo.isCond && !excInfo.passedCheck &&
                         !ctrl_q[ESX_CTRL_NOFAIL_BIT];
  assign smcTrapped    = trapCtrl.monitorCallTrap && excInfo.curLevel == 2'd1;

  always_comb begin
    raise_d                 = excTake;
    report_d.exceptionClass = ESX_EC_UNKNOWN;
    report_d.syndromeDetail = '0;
    report_d.targetLevel    = excInfo.trapTarget;
    unique case (excInfo.kind)
      EK_FP: begin
        raise_d                 = excTake && fpHit;
        report_d.exceptionClass = ESX_EC_FP;
        report_d.targetLevel    = fpLevel;
        report_d.syndromeDetail[ESX_CONDITION_CODE_FIELD_LSB +: 5] = cvCond;
      end
      EK_VEC: begin
        raise_d              = excTake && vecHit;
        report_d.targetLevel = vecLevel;
        report_d.exceptionClass = ctrl_q[ESX_CTRL_VEC_BIT] ? ESX_EC_VEC
                                                            : ESX_EC_UNKNOWN;
      end
      EK_ILLEGAL: report_d.exceptionClass = ILLEGAL_EC;
      EK_ALIGN:   report_d.exceptionClass = ALIGN_EC;
      EK_HVC: begin
        report_d.exceptionClass = HVC_EC;
        report_d.targetLevel    = 2'd2;
        report_d.syndromeDetail[15:0] = excInfo.callImmediate[15:0];
      end
      EK_SVC: begin
        report_d.targetLevel = (excInfo.curLevel == 2'd0) ? 2'd1 : excInfo.curLevel;
        if (excInfo.isa == IS_64) begin
          report_d.exceptionClass       = SVC64_EC;
          report_d.syndromeDetail[15:0] = excInfo.callImmediate[15:0];
        end else begin
          report_d.exceptionClass = SVC32_EC;
          raise_d = excTake && (!excInfo.isCond || excInfo.passedCheck);
          // a conditional call's immediate is undefined; zero is reported
          if (!excInfo.isCond && excInfo.isa == IS_NARROW) begin
            report_d.syndromeDetail[15:0] = {8'h00, excInfo.callImmediate[7:0]};
          end else if (!excInfo.isCond) begin
            report_d.syndromeDetail[15:0] = excInfo.callImmediate[15:0];
          end
        end
      end
      EK_SMC: begin
        report_d.targetLevel = smcTrapped ? 2'd2 : 2'd3;
        if (excInfo.isa == IS_64) begin
          report_d.exceptionClass       = SMC64_EC;
          report_d.syndromeDetail[15:0] = excInfo.callImmediate[15:0];
        end else begin
          report_d.exceptionClass = SMC32_EC;
          if (smcTrapped) begin
            report_d.syndromeDetail[ESX_PASSU_BIT] = passUncertain;
            if (passUncertain) begin
              report_d.syndromeDetail[ESX_CONDITION_CODE_FIELD_LSB +: 5] = cvCond;
            end
          end
        end
      end
      EK_SYSREG: begin
        report_d.exceptionClass = ESX_EC_SYSREG;
        report_d.syndromeDetail[ESX_OP0_LSB +: 2] = excInfo.sysopFirst;
        report_d.syndromeDetail[ESX_OP2_LSB +: 3] = excInfo.sysopThird;
        report_d.syndromeDetail[ESX_OP1_LSB +: 3] = excInfo.sysopSecond;
        report_d.syndromeDetail[ESX_CRN_LSB +: 4] = excInfo.sysPrimaryRegnum;
        report_d.syndromeDetail[ESX_RT_LSB +: 5]  = excInfo.transferRegnum;
        report_d.syndromeDetail[ESX_CRM_LSB +: 4] = excInfo.sysSecondaryRegnum;
        report_d.syndromeDetail[0] = excInfo.isRead;
      end
    endcase
  end

  // class, detail and level share one flop so they can never disagree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      report_q <= '0;
    end else if (raise_d) begin
      report_q <= report_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= raise_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q   <= 16'h0000;
      dropped_q <= 16'h0000;
    end else begin
      if (raise_d) begin
        count_q <= count_q + 16'h0001;
      end
      if (excTake && !raise_d) begin
        dropped_q <= dropped_q + 16'h0001;
      end
    end
  end

  assign reportValid = valid_q;
  assign report      = report_q;

  // apb: read data and error latched in setup, zero-wait access phase
  logic setup;
  logic mapped;
  assign setup  = psel && !penable;
  assign mapped = paddr == ESX_CTRL_OFS || paddr == ESX_SYND_OFS ||
                  paddr == ESX_STAT_OFS;
  assign pready = psel && penable;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= ESX_CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == ESX_CTRL_OFS) begin
      ctrl_q <= pwdata[ESX_CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      err_q <= !mapped;
      unique case (paddr)
        ESX_CTRL_OFS: prdata_q <= {28'h000_0000, ctrl_q};
        ESX_SYND_OFS: prdata_q <= {1'b0, report_q.exceptionClass, report_q.syndromeDetail};
        ESX_STAT_OFS: prdata_q <= {dropped_q[13:0], report_q.targetLevel, count_q};
        default:      prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = err_q && psel && penable;

  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_fp_low_zero;
    reportValid && report.exceptionClass == ESX_EC_FP |-> report.syndromeDetail[19:0] == 20'h0;
  endproperty
  a_fp_low_zero: assert property (p_fp_low_zero) else $error("fp syndrome low bits set");

  property p_vec_class;
    excTake && excInfo.kind == EK_VEC && vecHit |=> reportValid &&
      report.syndromeDetail == 25'h0 &&
      report.exceptionClass == ($past(ctrl_q[ESX_CTRL_VEC_BIT]) ? ESX_EC_VEC : ESX_EC_UNKNOWN);
  endproperty
  a_vec_class: assert property (p_vec_class) else $error("vector trap misreported");

  property p_vec_l1;
    excTake && excInfo.kind == EK_VEC && excInfo.curLevel <= 2'd1 &&
      !trapCtrl.vectorAccessEnableL1 |=> reportValid && report.targetLevel == 2'd1;
  endproperty
  a_vec_l1: assert property (p_vec_l1) else $error("vector trap not routed to level 1");

  property p_zero_synd;
    excTake && (excInfo.kind == EK_ILLEGAL || excInfo.kind == EK_ALIGN) |=>
      reportValid && report.syndromeDetail == 25'h0;
  endproperty
  a_zero_synd: assert property (p_zero_synd) else $error("illegal or align syndrome not zero");

  property p_hvc_imm;
    excTake && excInfo.kind == EK_HVC |=> reportValid &&
      report.syndromeDetail == {9'h000, $past(excInfo.callImmediate[15:0])};
  endproperty
  a_hvc_imm: assert property (p_hvc_imm) else $error("hypervisor immediate wrong");

  property p_svc_fail;
    excTake && excInfo.kind == EK_SVC && excInfo.isa != IS_64 && excInfo.isCond &&
      !excInfo.passedCheck |=> !reportValid;
  endproperty
  a_svc_fail: assert property (p_svc_fail) else $error("failed supervisor call raised");

  property p_smc_normal;
    excTake && excInfo.kind == EK_SMC && excInfo.isa != IS_64 && !smcTrapped |=>
      reportValid && report.syndromeDetail == 25'h0 && report.targetLevel == 2'd3;
  endproperty
  a_smc_normal: assert property (p_smc_normal) else $error("monitor call syndrome not zero");

  property p_smc_passu;
    reportValid && report.exceptionClass == SMC32_EC && !report.syndromeDetail[ESX_PASSU_BIT]
      |-> report.syndromeDetail[24:20] == 5'h00 && report.syndromeDetail[18:0] == 19'h0;
  endproperty
  a_smc_passu: assert property (p_smc_passu) else $error("condition fields without flag");

  property p_sysreg;
    excTake && excInfo.kind == EK_SYSREG |=> reportValid &&
      report.exceptionClass == ESX_EC_SYSREG && report.syndromeDetail[24:22] == 3'h0 &&
      report.syndromeDetail[21:20] == $past(excInfo.sysopFirst) &&
      report.syndromeDetail[0] == $past(excInfo.isRead);
  endproperty
  a_sysreg: assert property (p_sysreg) else $error("system move syndrome wrong");

  property p_cv64;
    excTake && excInfo.kind == EK_FP && excInfo.isa == IS_64 && fpHit |=>
      report.syndromeDetail[24:20] == 5'h1E;
  endproperty
  a_cv64: assert property (p_cv64) else $error("64-bit condition fields wrong");

  property p_wide_uncond;
    excTake && excInfo.kind == EK_FP && excInfo.isa == IS_WIDE && !excInfo.isCond && fpHit |=>
      report.syndromeDetail[24:20] == 5'h1E;
  endproperty
  a_wide_uncond: assert property (p_wide_uncond) else $error("wide condition wrong");

  property p_svc_imm8;
    excTake && excInfo.kind == EK_SVC && excInfo.isa == IS_NARROW && !excInfo.isCond |=>
      reportValid && report.syndromeDetail == {17'h00000, $past(excInfo.callImmediate[7:0])};
  endproperty
  a_svc_imm8: assert property (p_svc_imm8) else $error("short call immediate wrong");

  property p_smc_condition_code_field;
    excTake && excInfo.kind == EK_SMC && excInfo.isa == IS_WIDE &&
      trapCtrl.monitorCallTrap && excInfo.curLevel == 2'd1 &&
      excInfo.isCond && !excInfo.passedCheck && !ctrl_q[ESX_CTRL_NOFAIL_BIT] |=>
      reportValid && report.syndromeDetail == {1'b1, $past(excInfo.condCode), 1'b1, 19'h00000};
  endproperty
  a_smc_condition_code_field: assert property (p_smc_condition_code_field) else $error("trapped monitor fields wrong");

  property p_smc64_imm;
    excTake && excInfo.kind == EK_SMC && excInfo.isa == IS_64 |=> reportValid &&
      report.syndromeDetail == {9'h000, $past(excInfo.callImmediate[15:0])};
  endproperty
  a_smc64_imm: assert property (p_smc64_imm) else $error("monitor immediate wrong");

  property p_sysreg_regs;
    excTake && excInfo.kind == EK_SYSREG |=> report.syndromeDetail[13:1] ==
      {$past(excInfo.sysPrimaryRegnum), $past(excInfo.transferRegnum),
       $past(excInfo.sysSecondaryRegnum)};
  endproperty
  a_sysreg_regs: assert property (p_sysreg_regs) else $error("system move regs wrong");

  property p_valid_pulse;
    !excTake |=> !reportValid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("report without request");

  c_vec_trap:  cover property (excTake && excInfo.kind == EK_VEC ##1 reportValid);
  c_smc_trap:  cover property (reportValid && report.exceptionClass == SMC32_EC &&
                               report.syndromeDetail[ESX_PASSU_BIT]);
  c_svc_drop:  cover property (excTake && excInfo.kind == EK_SVC ##1 !reportValid);
  c_apb_read:  cover property (pready && !pwrite && paddr == ESX_SYND_OFS);

endmodule : esx_syndrome_encoder
`default_nettype wire

/* File: verification/esx_syndrome_encoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module esx_syndrome_encoder_tb;
  import esx_pkg::*;
  // neutral controls: every enable set, every trap bit clear
  localparam esx_trap_ctrl_type TC_OPEN = 9'h19A;
  logic              ref_clk;
  logic              rst_b;
  logic              excTake;
  esx_exc_type       excInfo;
  esx_trap_ctrl_type trapCtrl;
  esx_trap_ctrl_type tc;
  logic              reportValid;
  esx_report_type    report;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [31:0]       rd;
  logic              err;
  int                nMismatch;
  int                checkCount;
  int                nAcc;
  int                nDrop;

  esx_syndrome_encoder dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .excTake(excTake), .excInfo(excInfo),
    .trapCtrl(trapCtrl), .reportValid(reportValid), .report(report), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #2.5 ref_clk = ~ref_clk;

  task finish_test;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // request held until pready is sampled high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a stuck access
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic esx_exc_type mk(esx_kind_type k, esx_isa_type s, logic [1:0] cur,
                                     logic [23:0] imm, logic [3:0] cc, logic ic, logic ps);
    mk = '0;
    mk.kind = k;
    mk.isa = s;
    mk.curLevel = cur;
    mk.trapTarget = cur;
    mk.callImmediate = imm;
    mk.condCode = cc;
    mk.isCond = ic;
    mk.passedCheck = ps;
  endfunction : mk

  task rep_chk(input logic v, input logic [5:0] ec, input logic [24:0] det, input logic [1:0] lv);
    chk("reportValid", 32'(v), 32'(reportValid));
    if (v) begin
      nAcc++;
      chk("class", 32'(ec), 32'(report.exceptionClass));
      chk("detail", 32'(det), 32'(report.syndromeDetail));
      chk("level", 32'(lv), 32'(report.targetLevel));
    end else begin
      nDrop++;
    end
  endtask : rep_chk

  task exc(input esx_exc_type i, input logic v, input logic [5:0] ec, input logic [24:0] det,
           input logic [1:0] lv);
    @(posedge ref_clk);
    excTake  <= 1'b1;
    excInfo  <= i;
    trapCtrl <= tc;
    @(posedge ref_clk);
    excTake <= 1'b0;
    #1 rep_chk(v, ec, det, lv);
  endtask : exc

  task t_reset;
    @(posedge ref_clk);
    rst_b   <= 1'b0;
    excTake <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk("report", 32'h0, 32'(report));
    apb(1'b0, ESX_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b1, ESX_SYND_OFS, 32'hFFFFFFFF);
    apb(1'b0, ESX_SYND_OFS, 32'h0);
    chk("synd", 32'h0, rd);
    apb(1'b0, ESX_STAT_OFS, 32'h0);
    chk("stat", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    nAcc = 0;
    nDrop = 0;
    $display("test reset done");
  endtask : t_reset

  task t_fp;
    tc = TC_OPEN;
    exc(mk(EK_FP, IS_64, 2'd0, 24'h0, 4'h0, 1'b0, 1'b0), 1'b0, 6'h0, 25'h0, 2'd0);
    tc.fpAccessEnableL1 = 1'b0;
    exc(mk(EK_FP, IS_64, 2'd0, 24'h0, 4'h0, 1'b0, 1'b0), 1'b1, ESX_EC_FP, {5'h1E, 20'h0}, 2'd1);
    tc = TC_OPEN;
    tc.fpTrapBitL2 = 1'b1;
    exc(mk(EK_FP, IS_WIDE, 2'd1, 24'h0, 4'h5, 1'b1, 1'b0), 1'b1, ESX_EC_FP, {5'h15, 20'h0}, 2'd2);
    exc(mk(EK_FP, IS_NARROW, 2'd1, 24'h0, 4'h5, 1'b1, 1'b0), 1'b1, ESX_EC_FP, 25'h0, 2'd2);
    apb(1'b1, ESX_CTRL_OFS, 32'h7);
    exc(mk(EK_FP, IS_WIDE, 2'd1, 24'h0, 4'h5, 1'b1, 1'b1), 1'b1, ESX_EC_FP, {5'h1E, 20'h0}, 2'd2);
    exc(mk(EK_FP, IS_NARROW, 2'd1, 24'h0, 4'h5, 1'b1, 1'b0), 1'b1, ESX_EC_FP, {5'h15, 20'h0}, 2'd2);
    apb(1'b1, ESX_CTRL_OFS, 32'h1);
    tc = TC_OPEN;
    tc.fpTrapBitL3 = 1'b1;
    exc(mk(EK_FP, IS_WIDE, 2'd3, 24'h0, 4'h0, 1'b0, 1'b0), 1'b1, ESX_EC_FP, {5'h1E, 20'h0}, 2'd3);
    $display("test fp done");
  endtask : t_fp

  task t_vec;
    tc = TC_OPEN;
    tc.vectorAccessEnableL1 = 1'b0;
    exc(mk(EK_VEC, IS_64, 2'd1, 24'hFFFFFF, 4'hF, 1'b0, 1'b0), 1'b1, ESX_EC_VEC, 25'h0, 2'd1);
    // level 2 code is out of reach of the level-1 enable
    exc(mk(EK_VEC, IS_64, 2'd2, 24'h0, 4'h0, 1'b0, 1'b0), 1'b0, 6'h0, 25'h0, 2'd0);
    tc = TC_OPEN;
    tc.vectorTrapL2 = 1'b1;
    exc(mk(EK_VEC, IS_64, 2'd2, 24'h0, 4'h0, 1'b0, 1'b0), 1'b1, ESX_EC_VEC, 25'h0, 2'd2);
    tc = TC_OPEN;
    tc.vectorEnableL3 = 1'b0;
    exc(mk(EK_VEC, IS_64, 2'd3, 24'h0, 4'h0, 1'b0, 1'b0), 1'b1, ESX_EC_VEC, 25'h0, 2'd3);
    apb(1'b1, ESX_CTRL_OFS, 32'h0);
    exc(mk(EK_VEC, IS_64, 2'd3, 24'h0, 4'h0, 1'b0, 1'b0), 1'b1, ESX_EC_UNKNOWN, 25'h0, 2'd3);
    apb(1'b1, ESX_CTRL_OFS, 32'h1);
    $display("test vector done");
  endtask : t_vec

  task t_calls;
    tc = TC_OPEN;
    exc(mk(EK_ILLEGAL, IS_64, 2'd2, 24'hFFFFFF, 4'hF, 1'b1, 1'b1), 1'b1, 6'h30, 25'h0, 2'd2);
    exc(mk(EK_ALIGN, IS_WIDE, 2'd1, 24'hFFFFFF, 4'hF, 1'b1, 1'b1), 1'b1, 6'h31, 25'h0, 2'd1);
    exc(mk(EK_HVC, IS_64, 2'd1, 24'hA5C3F1, 4'h0, 1'b0, 1'b0), 1'b1, 6'h34, 25'hC3F1, 2'd2);
    exc(mk(EK_SVC, IS_64, 2'd0, 24'hA5C3F1, 4'h0, 1'b0, 1'b0), 1'b1, 6'h33, 25'hC3F1, 2'd1);
    exc(mk(EK_SVC, IS_NARROW, 2'd0, 24'h1234AB, 4'h0, 1'b0, 1'b0), 1'b1, 6'h32, 25'hAB, 2'd1);
    exc(mk(EK_SVC, IS_WIDE, 2'd2, 24'h1234AB, 4'h0, 1'b0, 1'b0), 1'b1, 6'h32, 25'h34AB, 2'd2);
    exc(mk(EK_SVC, IS_WIDE, 2'd1, 24'h1234AB, 4'h3, 1'b1, 1'b0), 1'b0, 6'h0, 25'h0, 2'd0);
    $display("test calls done");
  endtask : t_calls

  task t_smc;
    tc = TC_OPEN;
    exc(mk(EK_SMC, IS_WIDE, 2'd1, 24'h0, 4'h3, 1'b1, 1'b0), 1'b1, 6'h35, 25'h0, 2'd3);
    tc.monitorCallTrap = 1'b1;
    exc(mk(EK_SMC, IS_WIDE, 2'd1, 24'h0, 4'h3, 1'b1, 1'b0), 1'b1, 6'h35, {5'h13, 1'b1, 19'h0}, 2'd2);
    exc(mk(EK_SMC, IS_WIDE, 2'd1, 24'h0, 4'h3, 1'b1, 1'b1), 1'b1, 6'h35, 25'h0, 2'd2);
    exc(mk(EK_SMC, IS_WIDE, 2'd0, 24'h0, 4'h3, 1'b1, 1'b0), 1'b1, 6'h35, 25'h0, 2'd3);
    apb(1'b1, ESX_CTRL_OFS, 32'h9);
    exc(mk(EK_SMC, IS_WIDE, 2'd1, 24'h0, 4'h3, 1'b1, 1'b0), 1'b1, 6'h35, 25'h0, 2'd2);
    apb(1'b1, ESX_CTRL_OFS, 32'h1);
    exc(mk(EK_SMC, IS_64, 2'd1, 24'h7E5AA5, 4'h0, 1'b0, 1'b0), 1'b1, 6'h36, 25'h5AA5, 2'd2);
    tc = TC_OPEN;
    exc(mk(EK_SMC, IS_64, 2'd1, 24'h7E5AA5, 4'h0, 1'b0, 1'b0), 1'b1, 6'h36, 25'h5AA5, 2'd3);
    $display("test monitor call done");
  endtask : t_smc

  task t_sysreg;
    esx_exc_type a;
    esx_exc_type b;
    a = mk(EK_SYSREG, IS_64, 2'd1, 24'h0, 4'h0, 1'b0, 1'b0);
    b = a;
    {a.sysopFirst, a.sysopSecond, a.sysopThird} = {2'h3, 3'h5, 3'h6};
    {a.sysPrimaryRegnum, a.sysSecondaryRegnum, a.transferRegnum, a.isRead} = {4'hA, 4'h7, 5'h1D, 1'b1};
    {b.sysopFirst, b.sysopSecond, b.sysopThird, b.trapTarget} = {2'h1, 3'h2, 3'h3, 2'd2};
    {b.sysPrimaryRegnum, b.sysSecondaryRegnum, b.transferRegnum, b.isRead} = {4'h5, 4'hC, 5'h02, 1'b0};
    // two exceptions on consecutive edges: each report must match its own request
    @(posedge ref_clk);
    excTake  <= 1'b1;
    excInfo  <= a;
    trapCtrl <= tc;
    @(posedge ref_clk);
    excInfo <= b;
    #1 rep_chk(1'b1, ESX_EC_SYSREG, {3'h0, 2'h3, 3'h6, 3'h5, 4'hA, 5'h1D, 4'h7, 1'b1}, 2'd1);
    @(posedge ref_clk);
    excTake <= 1'b0;
    #1 rep_chk(1'b1, ESX_EC_SYSREG, {3'h0, 2'h1, 3'h3, 3'h2, 4'h5, 5'h02, 4'hC, 1'b0}, 2'd2);
    apb(1'b0, ESX_SYND_OFS, 32'h0);
    chk("synd", {1'b0, ESX_EC_SYSREG, 3'h0, 2'h1, 3'h3, 3'h2, 4'h5, 5'h02, 4'hC, 1'b0}, rd);
    apb(1'b0, ESX_STAT_OFS, 32'h0);
    chk("stat", {nDrop[13:0], 2'd2, nAcc[15:0]}, rd);
    $display("test system register done");
  endtask : t_sysreg

  initial begin
    repeat (5000) @(posedge ref_clk);
    nMismatch++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    excTake = 1'b0;
    excInfo = '0;
    trapCtrl = TC_OPEN;
    tc = TC_OPEN;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nMismatch = 0;
    checkCount = 0;
    t_reset();
    t_fp();
    t_vec();
    t_calls();
    t_smc();
    t_sysreg();
    t_reset();
    finish_test();
  end
endmodule : esx_syndrome_encoder_tb
`default_nettype wire
